// File: design/i2c_port_pkg.sv
// types of the two-wire register port
package i2c_port_pkg;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ADDR   = 7'h02,
        ST_RX     = 7'h04,
        ST_ACK    = 7'h08,
        ST_TX     = 7'h10,
        ST_MACK   = 7'h20,
        ST_IGNORE = 7'h40
    } port_state_t;

    typedef enum logic [2:0] {
        PH_PTR = 3'h1,
        PH_HI  = 3'h2,
        PH_LO  = 3'h4
    } write_phase_t;

endpackage

// File: design/i2c_port_regs.svh
// constants of the two-wire register port
`ifndef I2C_PORT_REGS_SVH
`define I2C_PORT_REGS_SVH

// upper six bits of the slave address
`define ADDR_UPPER 6'h0D
// bits per byte and counter width
`define BYTE_BITS 4'h8
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
// pointer step after a complete group
`define PTR_STEP 8'h01
// clock and link rates
`define CLK_HZ 40000000
`define SCL_MAX_HZ 400000
// least system cycles in one link clock period
`define SCL_PERIOD_CYCLES (`CLK_HZ / `SCL_MAX_HZ)
// fewest cycles per link period the sampler can serve
`define SCL_MIN_CYCLES 16

`endif

// File: design/i2c_slave_register_port.sv
// two-wire slave port onto the 16-bit control registers
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_regs.svh"

// Contract
// RL1: idle bus leaves both lines released high
// RL2: sda fall with scl high is start
// RL3: sda rise with scl high is stop
// RL4: first byte after start is address
// RL5: address 001101 plus select pin bit
// RL6: slave only, scl input, sda open drain
// RL7: eight bits then one acknowledge bit
// RL8: master releases sda, clocks acknowledge
// RL9: acknowledge every received byte when addressed
// RL10: master acknowledges all but last byte
// RL11: acknowledger holds sda low whole high
// RL12: master ends read with negative acknowledge
// RL13: after negative acknowledge release sda
// RL14: pointer one byte, data byte pairs
// RL15: write: start, address+0, ack, pointer, ack
// RL16: high byte first, write when pair done
// RL17: pointer increments after each complete pair
// RL18: read uses pointer write, repeated start
// RL19: read sends high then low while acked
// RL20: master ends read with nack, stop
// RL21: pointer selects same register map
// RL22: sda changes only while scl low
// RL23: bytes travel most significant bit first
// RL24: serve link clock up to 400 kHz
// RL25: foreign address: no ack, ignore traffic
// RL26: start or stop aborts partial pair
module i2c_slave_register_port
    import i2c_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_we,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    output logic bus_busy
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // RL24: link rate against sampler
    generate
        if (`SCL_PERIOD_CYCLES < `SCL_MIN_CYCLES) begin : g_bad_rate
            $error("system clock too slow for the link rate");
        end
    endgenerate
    // ----------------------------------------
    // input sampling
    // ----------------------------------------
    logic scl_s;
    logic sda_s;
    logic address_low_bit;
    logic scl_d;
    logic sda_d;
    pin_sync #(
        .W(3),
        .INIT(3'h7)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin({scl, sda_in, address_select_pin}),
        .level({scl_s, sda_s, address_low_bit})
    );
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    // ----------------------------------------
    // bus events
    // ----------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    // RL2: start detect
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    // RL3: stop detect
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    // ----------------------------------------
    // shared decode
    // ----------------------------------------
    port_state_t state;
    write_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] lo_hold;
    logic [7:0] hi_hold;
    logic rw;
    logic lo_turn;
    logic ack_ok;
    logic byte_done;
    logic ack_end;
    logic addr_match;
    logic load;
    logic [7:0] tx_byte;
    function automatic logic is_shift_state(input port_state_t s);
        is_shift_state = (s == ST_ADDR) || (s == ST_RX) || (s == ST_TX);
    endfunction
    // RL7: byte ends after eight bits
    assign byte_done = scl_fall && is_shift_state(state) && (cnt == `BYTE_BITS);
    assign ack_end = scl_fall && ((state == ST_ACK) || (state == ST_MACK));
    // RL5: own address compare
    assign addr_match = (rx[7:1] == {`ADDR_UPPER, address_low_bit});
    // RL19: next byte goes out while acked
    assign load = ack_end && (((state == ST_ACK) && rw) || ((state == ST_MACK) && ack_ok));
    assign tx_byte = lo_turn ? lo_hold : reg_rdata[15:8];
    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else if (start_cond) begin
            // RL4: address byte follows any start
            state <= ST_ADDR;
        end else if (stop_cond) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE, ST_IGNORE: state <= state;
                ST_ADDR: begin
                    // RL25: foreign address ignored until start
                    if (byte_done) begin
                        state <= addr_match ? ST_ACK : ST_IGNORE;
                    end
                end
                ST_RX: begin
                    if (byte_done) begin
                        state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state <= rw ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (byte_done) begin
                        state <= ST_MACK;
                    end
                end
                ST_MACK: begin
                    // RL13: negative acknowledge ends sending
                    if (scl_fall) begin
                        state <= ack_ok ? ST_TX : ST_IGNORE;
                    end
                end
            endcase
        end
    end
    // ----------------------------------------
    // bit counter and shifters
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= `CNT_ZERO;
        end else if (start_cond || ack_end) begin
            cnt <= `CNT_ZERO;
        end else if (scl_rise && is_shift_state(state)) begin
            cnt <= cnt + `CNT_ONE;
        end
    end
    // RL22: data sampled on the rising clock only
    // RL23: most significant bit first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx <= 8'h00;
        end else if (scl_rise && ((state == ST_ADDR) || (state == ST_RX))) begin
            rx <= {rx[6:0], sda_s};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ok <= 1'b0;
        end else if (scl_rise && (state == ST_MACK)) begin
            ack_ok <= ~sda_s;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rw <= 1'b0;
        end else if (start_cond) begin
            rw <= 1'b0;
        end else if ((state == ST_ADDR) && byte_done && addr_match) begin
            rw <= rx[0];
        end
    end
    // ----------------------------------------
    // transmit path
    // ----------------------------------------
    // RL19: high byte then low byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx <= 8'h00;
            lo_hold <= 8'h00;
            lo_turn <= 1'b0;
        end else if (start_cond) begin
            lo_turn <= 1'b0;
        end else if (load) begin
            tx <= tx_byte;
            lo_turn <= ~lo_turn;
            if (!lo_turn) begin
                lo_hold <= reg_rdata[7:0];
            end
        end else if (scl_fall && (state == ST_TX) && !byte_done) begin
            tx <= {tx[6:0], 1'b0};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd <= 1'b0;
        end else begin
            reg_rd <= load && !lo_turn;
        end
    end
    // ----------------------------------------
    // data line driver
    // ----------------------------------------
    // RL6: sda only ever pulled low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond) begin
            // RL1: released between transfers
            sda_oe <= 1'b0;
        end else if (byte_done && (state == ST_ADDR)) begin
            // RL9: acknowledge own address
            sda_oe <= addr_match;
        end else if (byte_done && (state == ST_RX)) begin
            // RL9: acknowledge every received byte
            sda_oe <= 1'b1;
        end else if (ack_end) begin
            // RL11: held low until the acknowledge clock falls
            sda_oe <= load ? ~tx_byte[7] : 1'b0;
        end else if (byte_done && (state == ST_TX)) begin
            // RL8: release for the master acknowledge
            sda_oe <= 1'b0;
        end else if (scl_fall && (state == ST_TX)) begin
            // RL22: change only after the clock falls
            sda_oe <= ~tx[6];
        end
    end
    // ----------------------------------------
    // write path and pointer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_PTR;
        end else if (start_cond || stop_cond) begin
            // RL26: partial pair dropped
            phase <= PH_PTR;
        end else if (byte_done && (state == ST_RX)) begin
            // RL15: pointer byte, then pairs
            unique case (phase)
                PH_PTR: phase <= PH_HI;
                PH_HI: phase <= PH_LO;
                PH_LO: phase <= PH_HI;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_hold <= 8'h00;
            reg_wdata <= 16'h0000;
            reg_we <= 1'b0;
        end else begin
            reg_we <= 1'b0;
            // RL14: two bytes make one word
            if (byte_done && (state == ST_RX) && (phase == PH_HI)) begin
                hi_hold <= rx;
            end
            // RL16: register written once the pair is complete
            if (byte_done && (state == ST_RX) && (phase == PH_LO)) begin
                reg_wdata <= {hi_hold, rx};
                reg_we <= 1'b1;
            end
        end
    end

    // RL21: pointer drives the register map directly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr <= 8'h00;
        end else if (byte_done && (state == ST_RX) && (phase == PH_PTR)) begin
            reg_addr <= rx;
        end else if (reg_we || (byte_done && (state == ST_TX) && !lo_turn)) begin
            // RL17: step after each complete group
            reg_addr <= reg_addr + `PTR_STEP;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_busy <= 1'b0;
        end else if (start_cond) begin
            bus_busy <= 1'b1;
        end else if (stop_cond) begin
            bus_busy <= 1'b0;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_addr_done;
        (state == ST_ADDR) && byte_done;
    endsequence
    sequence s_nack_end;
        (state == ST_MACK) && scl_fall && !ack_ok;
    endsequence
    a_idle_released: assert property (@(posedge clk) disable iff (!rst_n) // RL1
        (state == ST_IDLE) |-> !sda_oe)
        else $error("sda driven while idle");
    a_start_addr: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        start_cond |=> (state == ST_ADDR) && (cnt == `CNT_ZERO) && !sda_oe)
        else $error("start did not open an address byte");
    a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        stop_cond |=> (state == ST_IDLE) && !sda_oe && !bus_busy)
        else $error("stop did not free the port");
    a_addr_ack: assert property (@(posedge clk) disable iff (!rst_n) // RL5
        s_addr_done ##0 addr_match |=> sda_oe && (state == ST_ACK))
        else $error("own address not acknowledged");
    a_foreign_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RL25
        s_addr_done ##0 !addr_match |=> (!sda_oe && (state == ST_IGNORE))[*2])
        else $error("foreign address answered");
    a_drive_states: assert property (@(posedge clk) disable iff (!rst_n) // RL6
        sda_oe |-> ((state == ST_ACK) || (state == ST_TX) || (state == ST_MACK)))
        else $error("sda driven outside acknowledge or send");
    a_nack_release: assert property (@(posedge clk) disable iff (!rst_n) // RL13
        s_nack_end |=> !sda_oe && (state == ST_IGNORE))
        else $error("sda held after negative acknowledge");
    a_write_step: assert property (@(posedge clk) disable iff (!rst_n) // RL17
        reg_we |=> reg_addr == ($past(reg_addr) + `PTR_STEP))
        else $error("pointer did not step after write");
    a_abort_pair: assert property (@(posedge clk) disable iff (!rst_n) // RL26
        (start_cond || stop_cond) |=> (phase == PH_PTR) && !reg_we)
        else $error("partial pair survived start or stop");
    a_ack_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL11
        ((state == ST_ACK) && sda_oe && scl_rise) |=> sda_oe throughout scl_s[*2])
        else $error("acknowledge released during clock high");

endmodule

`default_nettype wire

// File: design/pin_sync.sv
// three-stage input sampler with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    generate
        if (W < 1) begin : g_bad_width
            $error("pin_sync width must be at least one");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts once stages two and three agree
    logic [W-1:0] agree;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign agree[i] = (s2[i] == s3[i]);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= INIT;
        end else begin
            level <= (level & ~agree) | (s3 & agree);
        end
    end

endmodule

`default_nettype wire

// File: tb/i2c_master_model.sv
// bus master model for the two-wire register port
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model #(
    parameter int QUARTER_NS = 625
) (
    input wire logic sda,
    output logic scl,
    output logic master_oe
);
    // ----------------------------------------
    // idle and bit level
    // ----------------------------------------
    // lines rest high
    initial begin
        scl = 1'b1;
        master_oe = 1'b0;
    end

    // data moves while scl low, 400 kHz, ack sampled at mid and end of high
    task automatic clock_bit(input logic b, output logic r);
        master_oe = ~b;
        #(QUARTER_NS);
        scl = 1'b1;
        #(QUARTER_NS);
        r = sda;
        #(QUARTER_NS - 5);
        r = r | sda;
        #5;
        scl = 1'b0;
        #(QUARTER_NS);
    endtask

    // ----------------------------------------
    // framing
    // ----------------------------------------
    // start and repeated start
    task automatic start_cond();
        master_oe = 1'b0;
        #(QUARTER_NS);
        scl = 1'b1;
        #(QUARTER_NS);
        master_oe = 1'b1;
        #(QUARTER_NS);
        scl = 1'b0;
        #(QUARTER_NS);
    endtask

    task automatic stop_cond();
        master_oe = 1'b1;
        #(QUARTER_NS);
        scl = 1'b1;
        #(QUARTER_NS);
        master_oe = 1'b0;
        #(2 * QUARTER_NS);
    endtask

    // msb first, sda released for ack clock
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], r);
        end
        clock_bit(1'b1, r);
        acked = ~r;
    endtask

    // ack all but last byte read
    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, r);
            b[i] = r;
        end
        clock_bit(~ack, r);
    endtask
endmodule
`default_nettype wire

// File: tb/i2c_slave_register_port_test.sv
// self-checking bench of the two-wire register port
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_regs.svh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module i2c_slave_register_port_test;
    // ----------------------------------------
    // signals and models
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n, sel, scl, master_oe, sda, sda_out, sda_oe, reg_we, reg_rd, bus_busy;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [15:0] regs [256];
    int mismatches, n_checks, cycles, rd_pulses;

    assign sda = ~(sda_oe | master_oe);
    assign reg_rdata = regs[reg_addr];

    i2c_slave_register_port DUT (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(sel), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_busy(bus_busy));

    i2c_master_model master (.sda(sda), .scl(scl), .master_oe(master_oe));

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (reg_we === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (reg_rd === 1'b1) begin
            rd_pulses++;
        end
        if (cycles == 60000) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [7:0] addr_byte(input logic rw);
        return {`ADDR_UPPER, sel, rw};
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle();
        `CHK(sda_oe, 1'b0)
        `CHK(sda_out, 1'b0)
        `CHK(bus_busy, 1'b0)
    endtask

    task automatic t_write();
        logic [5:0] a;
        logic [7:0] p;
        for (int s = 0; s < 2; s++) begin
            sel = s[0];
            repeat (4) @(negedge clk);
            p = 8'(16 + 2 * s);
            master.start_cond();
            master.send_byte(addr_byte(1'b0), a[0]);
            `CHK(bus_busy, 1'b1)
            master.send_byte(p, a[1]);
            master.send_byte(8'hA5, a[2]);
            master.send_byte(8'(s), a[3]);
            master.send_byte(8'h5A, a[4]);
            master.send_byte(8'hC3, a[5]);
            master.stop_cond();
            `CHK(a, 6'h3F)
            `CHK(regs[p], {8'hA5, 8'(s)})
            `CHK(regs[p + 8'h01], 16'h5AC3)
            `CHK(reg_addr, p + 8'h02)
            `CHK(bus_busy, 1'b0)
        end
    endtask

    task automatic t_read();
        logic [2:0] a;
        logic [7:0] d [4];
        master.start_cond();
        master.send_byte(addr_byte(1'b0), a[0]);
        master.send_byte(8'h11, a[1]);
        master.start_cond();
        master.send_byte(addr_byte(1'b1), a[2]);
        for (int i = 0; i < 4; i++) begin
            master.read_byte(i < 3, d[i]);
        end
        `CHK(sda, 1'b1)
        master.stop_cond();
        `CHK(a, 3'h7)
        `CHK({d[0], d[1]}, 16'h5AC3)
        `CHK({d[2], d[3]}, 16'hA501)
        `CHK(reg_addr, 8'h13)
        `CHK(rd_pulses, 2)
    endtask

    task automatic t_foreign();
        logic [5:0] up [3];
        logic [3:0] a;
        logic b0, b1;
        up = '{6'h0D, 6'h2D, 6'h05};
        for (int k = 0; k < 3; k++) begin
            master.start_cond();
            master.send_byte({up[k], (k == 0) ? ~sel : sel, 1'b0}, a[0]);
            master.send_byte(8'h30, a[1]);
            master.send_byte(8'hEE, a[2]);
            master.send_byte(8'hEE, a[3]);
            `CHK(a, 4'h0)
            `CHK(regs[8'h30], 16'h30CF)
            master.start_cond();
            master.send_byte(addr_byte(1'b0), b0);
            master.send_byte(8'h30, b1);
            master.stop_cond();
            `CHK({b0, b1}, 2'h3)
        end
    endtask

    task automatic t_abort();
        logic a;
        for (int k = 0; k < 2; k++) begin
            master.start_cond();
            master.send_byte(addr_byte(1'b0), a);
            master.send_byte(8'h20, a);
            master.send_byte(8'hBE, a);
            if (k == 1) begin
                master.start_cond();
            end
            master.stop_cond();
            `CHK(regs[8'h20], 16'h20DF)
        end
        master.start_cond();
        master.send_byte(addr_byte(1'b0), a);
        master.send_byte(8'h20, a);
        master.send_byte(8'h11, a);
        master.send_byte(8'h22, a);
        master.stop_cond();
        `CHK(regs[8'h20], 16'h1122)
    endtask

    // ----------------------------------------
    // run and verdict
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        sel = 1'b0;
        mismatches = 0;
        n_checks = 0;
        cycles = 0;
        rd_pulses = 0;
        for (int i = 0; i < 256; i++) begin
            regs[i] <= {8'(i), ~8'(i)};
        end
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        t_idle();
        t_write();
        t_read();
        t_foreign();
        t_abort();
        summarize();
    end
endmodule
`default_nettype wire
